/* File: rtl/cams_regs.vh */
// Constants for the address-mode and special-sequence block.
`ifndef CAMS_REGS_VH
`define CAMS_REGS_VH

// Operand addressing modes, as presented on ea_mode.
`define CAMS_INHERENT_MODE            4'h0
`define CAMS_LITERAL_OPERAND_MODE     4'h1
`define CAMS_DIRECT_MODE              4'h2
`define CAMS_FULL_ADDRESS_MODE        4'h3
`define CAMS_INDEX_BASE_MODE          4'h4
`define CAMS_INDEX_POSTINC_MODE       4'h5
`define CAMS_INDEX_OFFSET8_MODE       4'h6
`define CAMS_INDEX_OFFSET8_POSTINC_MODE 4'h7
`define CAMS_INDEX_OFFSET16_MODE      4'h8
`define CAMS_STACK_OFFSET8_MODE       4'h9
`define CAMS_STACK_OFFSET16_MODE      4'ha

// Sequencer states.
`define CAMS_ST_RUN     4'h0
`define CAMS_ST_STACK   4'h1
`define CAMS_ST_VEC_HI  4'h2
`define CAMS_ST_VEC_LO  4'h3
`define CAMS_ST_FREE    4'h4
`define CAMS_ST_FILL    4'h5
`define CAMS_ST_WAIT    4'h6
`define CAMS_ST_STOP    4'h7
`define CAMS_ST_DEBUG_PIN    4'h8
`define CAMS_ST_RESET   4'h9

// Reset values and fixed addresses.
`define CAMS_RESET_SP       16'h00ff
`define CAMS_RESET_VECTOR   16'hfffe
`define CAMS_DIRECT_PAGE_HI 8'h00
`define CAMS_POSTINC_STEP   16'h0001

// Sequence lengths in bus cycles.
`define CAMS_STACK_BYTES 3'h5
`define CAMS_FILL_BYTES  3'h3

// Fixed condition code bits.
`define CAMS_CCR_MASK_BIT 3
`define CAMS_CCR_ONES     8'h60

`endif

/* File: rtl/cams_ea_gen.v */
// Combinational effective-address generator for all operand modes.
`timescale 1ns/100ps
`default_nettype none
`include "cams_regs.vh"

module cams_ea_gen (
	input  wire [3:0]  mode,
	input  wire [7:0]  op_hi,
	input  wire [7:0]  op_lo,
	input  wire [15:0] index_pair,
	input  wire [15:0] stack_pointer,
	input  wire [15:0] program_counter,
	input  wire        for_copy,
	input  wire        for_compare,
	output reg  [15:0] ea,
	output reg         mem_access,
	output reg         post_inc,
	output reg         illegal
);
	// Byte-wide offsets widened once; sums are cut to 16 bits so they wrap.
	wire [15:0] off8;
	wire [15:0] off16;
	assign off8  = {8'h00, op_lo};
	assign off16 = {op_hi, op_lo};

	// One case per mode; every output has a value on every path.
	always @* begin
		ea         = 16'h0000;
		mem_access = 1'b1;
		post_inc   = 1'b0;
		illegal    = 1'b0;
		case (mode)
			`CAMS_INHERENT_MODE: begin
				// Operands live in core registers, so the bus stays idle.
				mem_access = 1'b0;
			end
			`CAMS_LITERAL_OPERAND_MODE: begin
				// The operand sits right after the opcode.
				ea = program_counter;
			end
			`CAMS_DIRECT_MODE: begin
				ea = {`CAMS_DIRECT_PAGE_HI, op_lo};
			end
			`CAMS_FULL_ADDRESS_MODE: begin
				ea = off16;
			end
			`CAMS_INDEX_BASE_MODE: begin
				ea = index_pair;
			end
			`CAMS_INDEX_POSTINC_MODE: begin
				ea       = index_pair;
				post_inc = 1'b1;
				illegal  = ~(for_copy | for_compare);
			end
			`CAMS_INDEX_OFFSET8_MODE: begin
				ea = index_pair + off8;
			end
			`CAMS_INDEX_OFFSET8_POSTINC_MODE: begin
				ea       = index_pair + off8;
				post_inc = 1'b1;
				illegal  = ~for_compare;
			end
			`CAMS_INDEX_OFFSET16_MODE: begin
				ea = index_pair + off16;
			end
			`CAMS_STACK_OFFSET8_MODE: begin
				ea = stack_pointer + off8;
			end
			`CAMS_STACK_OFFSET16_MODE: begin
				ea = stack_pointer + off16;
			end
			default: begin
				// Unknown codes make no access and are flagged.
				mem_access = 1'b0;
				illegal    = 1'b1;
			end
		endcase
	end
endmodule
`default_nettype wire

/* File: rtl/cams_core.v */
// Address-mode engine and special sequences of the 8-bit core.
// Overview of operation
// - One 16-bit, 64-Kbyte address space for everything.
// - Branch tests use mode; target always relative.
// - Inherent mode makes no memory operand access.
// - Taken branch adds sign-extended displacement to counter.
// - Immediate operand follows opcode, high byte first.
// - Direct address is zero page plus byte.
// - Extended address read high byte first.
// - Index pair plus none, 8 or 16-bit offset.
// - Stack pointer plus 8 or 16-bit offset.
// - Post-increment index pair; restricted to copy/compare, offset form to compare only.
// - Reset abandons operation immediately.
// - Six-cycle reset vector fetch and queue fill.
// - Interrupt waits for boundary; highest pending vector.
// - Push pc low, pc high, index low, accumulator, flags.
// - Set mask, vector high, low, free, three fetches.
// - Upper index byte is never stacked.
// - Software trap enters regardless of mask.
// - Wait clears mask, gates clocks until wakeup.
// - Debug enter command wakes wait into background.
// - Debug enable keeps oscillator; stop wakes to background.
// - Halt instruction enters background; resume by command.
// - Mask blocks interrupts; none right after mask clear.
// - Reset forces stack pointer to 00ff.
`timescale 1ns/100ps
`default_nettype none
`include "cams_regs.vh"

module cams_core (
	input  wire        clk,
	input  wire        resetn,
	input  wire        ea_start,
	input  wire [3:0]  ea_mode,
	input  wire        ea_for_copy,
	input  wire        ea_for_compare,
	input  wire [7:0]  op_hi,
	input  wire [7:0]  op_lo,
	input  wire [15:0] index_pair,
	input  wire        branch_start,
	input  wire [7:0]  branch_disp,
	input  wire        branch_taken,
	input  wire        pc_step,
	input  wire        boundary,
	input  wire        irq_pending,
	input  wire [15:0] irq_vector,
	input  wire        soft_trap_instr,
	input  wire        wait_instr,
	input  wire        stop_instr,
	input  wire        halt_to_debug_instr,
	input  wire        mask_clear_instr,
	input  wire [7:0]  index_low,
	input  wire [7:0]  accumulator,
	input  wire [7:0]  ccr_flags,
	input  wire [7:0]  mem_rdata,
	input  wire        debug_enter_cmd,
	input  wire        debug_resume_cmd,
	input  wire        single_step_cmd,
	input  wire        tagged_resume_cmd,
	input  wire        debug_mode_enable_bit,
	output reg  [15:0] ea_addr,
	output reg         ea_valid,
	output reg         ea_mem_access,
	output reg         ea_illegal,
	output reg         index_load,
	output reg  [15:0] index_value,
	output reg  [15:0] program_counter,
	output reg  [15:0] stack_pointer,
	output reg         interrupt_mask,
	output reg  [15:0] mem_addr,
	output reg         mem_rd,
	output reg         mem_wr,
	output reg  [7:0]  mem_wdata,
	output reg         cpu_clk_en,
	output reg         osc_keep_on,
	output reg         in_background,
	output reg         seq_busy
);
	// Sequencer state and the byte counter shared by stacking and fill.
	reg [3:0]  state;
	reg [2:0]  cnt;
	// Vector address latched when an entry sequence starts.
	reg [15:0] vec_addr;
	// High vector byte held until the low byte arrives.
	reg [7:0]  vec_hi;

	// Combinational address result for the current request.
	wire [15:0] gen_ea;
	wire        gen_mem;
	wire        gen_inc;
	wire        gen_bad;

	// Sign-extended branch displacement, kept at full address width.
	wire [15:0] disp_ext;
	assign disp_ext = {{8{branch_disp[7]}}, branch_disp};

	// Interrupt is acceptable only when unmasked and not just unmasked.
	wire irq_ok;
	assign irq_ok = irq_pending & ~interrupt_mask & ~mask_clear_instr;

	// Any command that hands control back to the user program.
	wire resume_any;
	assign resume_any = debug_resume_cmd | single_step_cmd | tagged_resume_cmd;

	// Byte pushed in each stacking slot; the upper index byte has no slot.
	reg [7:0] push_byte;
	always @* begin
		case (cnt)
			3'h0: push_byte = program_counter[7:0];
			3'h1: push_byte = program_counter[15:8];
			3'h2: push_byte = index_low;
			3'h3: push_byte = accumulator;
			default: begin
				// Flags byte carries the live mask and the fixed ones.
				push_byte = ccr_flags | `CAMS_CCR_ONES;
				push_byte[`CAMS_CCR_MASK_BIT] = interrupt_mask;
			end
		endcase
	end

	// Address generation lives in its own leaf so the modes read cleanly.
	cams_ea_gen u_ea_gen (
		.mode            (ea_mode),
		.op_hi           (op_hi),
		.op_lo           (op_lo),
		.index_pair      (index_pair),
		.stack_pointer   (stack_pointer),
		.program_counter (program_counter),
		.for_copy        (ea_for_copy),
		.for_compare     (ea_for_compare),
		.ea              (gen_ea),
		.mem_access      (gen_mem),
		.post_inc        (gen_inc),
		.illegal         (gen_bad)
	);

	// Operand address path: registered once per request in run state.
	// Branch tests use this path for the tested operand only; the branch
	// target never comes from here but from the displacement path below.
	always @(posedge clk) begin
		if (!resetn) begin
			ea_addr       <= 16'h0000;
			ea_valid      <= 1'b0;
			ea_mem_access <= 1'b0;
			ea_illegal    <= 1'b0;
			index_load    <= 1'b0;
			index_value   <= 16'h0000;
		end else begin
			ea_valid   <= 1'b0;
			index_load <= 1'b0;
			if (ea_start && state == `CAMS_ST_RUN) begin
				// All addresses are 16 bits across one flat space.
				ea_addr       <= gen_ea;
				ea_valid      <= 1'b1;
				ea_mem_access <= gen_mem & ~gen_bad;
				ea_illegal    <= gen_bad;
				// The increment is handed back with the operand access, so
				// the pair changes only after that fetch has used it.
				if (gen_inc && !gen_bad) begin
					index_load  <= 1'b1;
					index_value <= index_pair + `CAMS_POSTINC_STEP;
				end
			end
		end
	end

	// Main sequencer: run, entry, low-power and background states.
	// Reset is checked first so any sequence is dropped mid-way.
	always @(posedge clk) begin
		if (!resetn) begin
			// Abandon everything; no boundary is awaited.
			state           <= `CAMS_ST_RESET;
			cnt             <= 3'h0;
			vec_addr        <= `CAMS_RESET_VECTOR;
			vec_hi          <= 8'h00;
			program_counter <= 16'h0000;
			stack_pointer   <= `CAMS_RESET_SP;
			interrupt_mask  <= 1'b1;
			mem_addr        <= 16'h0000;
			mem_rd          <= 1'b0;
			mem_wr          <= 1'b0;
			mem_wdata       <= 8'h00;
			cpu_clk_en      <= 1'b1;
			osc_keep_on     <= 1'b0;
			in_background   <= 1'b0;
			seq_busy        <= 1'b1;
		end else begin
			// Bus strobes are single-cycle unless a state renews them.
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			// The oscillator may only stop in stop mode without debug.
			osc_keep_on <= debug_mode_enable_bit;
			case (state)
				`CAMS_ST_RESET: begin
					// First cycle after release: start the six-cycle walk
					// that shares the vector and fill tail with interrupts.
					state    <= `CAMS_ST_VEC_HI;
					mem_addr <= vec_addr;
					mem_rd   <= 1'b1;
				end
				`CAMS_ST_RUN: begin
					seq_busy <= 1'b0;
					// Ordinary counter movement between boundaries.
					if (branch_start && branch_taken) begin
						program_counter <= program_counter + disp_ext;
					end else if (pc_step) begin
						program_counter <= program_counter + 16'h0001;
					end
					// Special events are only honoured at a boundary, so
					// the current instruction always completes first.
					if (boundary) begin
						if (halt_to_debug_instr) begin
							state         <= `CAMS_ST_DEBUG_PIN;
							in_background <= 1'b1;
							seq_busy      <= 1'b1;
						end else if (soft_trap_instr) begin
							// The trap ignores the mask on purpose.
							vec_addr <= irq_vector;
							state    <= `CAMS_ST_STACK;
							cnt      <= 3'h0;
							seq_busy <= 1'b1;
						end else if (irq_ok) begin
							// Vector of the highest pending source now.
							vec_addr <= irq_vector;
							state    <= `CAMS_ST_STACK;
							cnt      <= 3'h0;
							seq_busy <= 1'b1;
						end else if (wait_instr) begin
							interrupt_mask <= 1'b0;
							cpu_clk_en     <= 1'b0;
							state          <= `CAMS_ST_WAIT;
							seq_busy       <= 1'b1;
						end else if (stop_instr) begin
							cpu_clk_en <= 1'b0;
							state      <= `CAMS_ST_STOP;
							seq_busy   <= 1'b1;
						end
					end
				end
				`CAMS_ST_STACK: begin
					// Five writes, descending; the pointer moves after each.
					mem_addr      <= stack_pointer;
					mem_wr        <= 1'b1;
					mem_wdata     <= push_byte;
					stack_pointer <= stack_pointer - 16'h0001;
					if (cnt == `CAMS_STACK_BYTES - 3'h1) begin
						// Mask goes up only after the flags byte is out.
						interrupt_mask <= 1'b1;
						state          <= `CAMS_ST_VEC_HI;
						cnt            <= 3'h0;
					end else begin
						cnt <= cnt + 3'h1;
					end
				end
				`CAMS_ST_VEC_HI: begin
					// After stacking the first read is issued here; in the
					// reset path it was issued one state earlier.
					if (!mem_rd) begin
						mem_addr <= vec_addr;
						mem_rd   <= 1'b1;
					end else begin
						vec_hi   <= mem_rdata;
						mem_addr <= vec_addr + 16'h0001;
						mem_rd   <= 1'b1;
						state    <= `CAMS_ST_VEC_LO;
					end
				end
				`CAMS_ST_VEC_LO: begin
					// Low half completes the new counter; bus is left free.
					program_counter <= {vec_hi, mem_rdata};
					state           <= `CAMS_ST_FREE;
				end
				`CAMS_ST_FREE: begin
					// One idle bus cycle, then queue fill from the target.
					mem_addr <= program_counter;
					mem_rd   <= 1'b1;
					state    <= `CAMS_ST_FILL;
					cnt      <= 3'h0;
				end
				`CAMS_ST_FILL: begin
					// Three program bytes fill the queue, counter follows.
					program_counter <= program_counter + 16'h0001;
					if (cnt == `CAMS_FILL_BYTES - 3'h1) begin
						state <= `CAMS_ST_RUN;
						cnt   <= 3'h0;
					end else begin
						mem_addr <= program_counter + 16'h0001;
						mem_rd   <= 1'b1;
						cnt      <= cnt + 3'h1;
					end
				end
				`CAMS_ST_WAIT: begin
					// Debug entry wins so a host can always get in.
					if (debug_enter_cmd) begin
						cpu_clk_en    <= 1'b1;
						in_background <= 1'b1;
						state         <= `CAMS_ST_DEBUG_PIN;
					end else if (irq_pending && !interrupt_mask) begin
						// Clocks return, then the normal entry runs.
						cpu_clk_en <= 1'b1;
						vec_addr   <= irq_vector;
						state      <= `CAMS_ST_STACK;
						cnt        <= 3'h0;
					end
				end
				`CAMS_ST_STOP: begin
					// Without the enable the oscillator is off and the
					// command cannot be seen, so it is ignored here.
					if (debug_enter_cmd && debug_mode_enable_bit) begin
						cpu_clk_en    <= 1'b1;
						in_background <= 1'b1;
						state         <= `CAMS_ST_DEBUG_PIN;
					end else if (irq_pending && !interrupt_mask) begin
						cpu_clk_en <= 1'b1;
						vec_addr   <= irq_vector;
						state      <= `CAMS_ST_STACK;
						cnt        <= 3'h0;
					end
				end
				`CAMS_ST_DEBUG_PIN: begin
					// Only a host command (or reset) leaves background.
					if (resume_any) begin
						in_background <= 1'b0;
						state         <= `CAMS_ST_RUN;
					end
				end
				default: begin
					// Unreachable codes recover through the reset walk.
					state <= `CAMS_ST_RESET;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: tb/cams_mem_model.sv */
// Behavioural memory and register space on the far side of the core's bus.
`timescale 1ns/100ps
`default_nettype none
module cams_mem_model (
	input  wire logic        clk,
	input  wire logic [15:0] mem_addr,
	input  wire logic        mem_rd,
	input  wire logic        mem_wr,
	input  wire logic [7:0]  mem_wdata,
	output var  logic [7:0]  mem_rdata
);
	logic [7:0] mem [0:65535];
	logic [7:0] last;          // Last byte read, kept so an idle bus never repeats it.
	// A filled pattern lets the bench see which places were never written.
	initial begin
		last = 8'h00;
		for (int i = 0; i < 65536; i++)
			mem[i] = 8'hee;
	end
	// Writes and reads complete on the edge that samples the strobe.
	always @(posedge clk) begin
		if (mem_wr)
			mem[mem_addr] <= mem_wdata;
		if (mem_rd)
			last <= mem[mem_addr];
	end
	// Data is valid only with the strobe; otherwise the bus shows the inverse, not stale data.
	always @* begin
		if (mem_rd)
			mem_rdata = mem[mem_addr];
		else
			mem_rdata = ~last;
	end
endmodule
`default_nettype wire

/* File: tb/cams_core_chk.sv */
// Concurrent checks on the ports of the address-mode and sequence core.
`timescale 1ns/100ps
`default_nettype none
module cams_chk (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        ea_start,
	input wire logic [3:0]  ea_mode,
	input wire logic [7:0]  op_lo,
	input wire logic [15:0] index_pair,
	input wire logic        branch_start,
	input wire logic [7:0]  branch_disp,
	input wire logic        branch_taken,
	input wire logic        boundary,
	input wire logic        irq_pending,
	input wire logic        soft_trap_instr,
	input wire logic        wait_instr,
	input wire logic        halt_to_debug_instr,
	input wire logic        debug_resume_cmd,
	input wire logic [15:0] ea_addr,
	input wire logic        ea_mem_access,
	input wire logic        index_load,
	input wire logic [15:0] index_value,
	input wire logic [15:0] program_counter,
	input wire logic [15:0] stack_pointer,
	input wire logic        interrupt_mask,
	input wire logic [15:0] mem_addr,
	input wire logic        mem_rd,
	input wire logic        mem_wr,
	input wire logic        cpu_clk_en,
	input wire logic        in_background,
	input wire logic        seq_busy
);
	wire        run = !seq_busy && cpu_clk_en && !in_background; // Requests count only here.
	wire        req = ea_start && run;
	wire [15:0] disp_ext = {{8{branch_disp[7]}}, branch_disp};
	default clocking dc @(posedge clk); endclocking
	default disable iff (!resetn);
	// Vector reads, one idle cycle, then three queue fills.
	sequence reset_fetch;
		mem_rd && mem_addr == 16'hfffe ##1 mem_rd && mem_addr == 16'hffff ##1 !mem_rd ##1 mem_rd [*3];
	endsequence
	// Five stack writes, mask set by the vector reads, a free cycle, three fills.
	sequence entry_steps;
		mem_wr [*5] ##1 mem_rd && interrupt_mask ##1 mem_rd ##1 !mem_rd && !mem_wr ##1 mem_rd [*3];
	endsequence
	chk_direct_page: assert property (req && ea_mode == 4'h2 |=> ea_addr == {8'h00, $past(op_lo)})
		else $error("direct address wrong");
	chk_index_sum: assert property (req && ea_mode == 4'h6 |=> ea_addr == $past(index_pair) + $past(op_lo))
		else $error("indexed address wrong");
	chk_stack_sum: assert property (req && ea_mode == 4'h9 |=> ea_addr == $past(stack_pointer) + $past(op_lo))
		else $error("stack address wrong");
	chk_no_operand: assert property (req && ea_mode == 4'h0 |=> ea_valid_gap())
		else $error("inherent mode touched memory");
	chk_postinc_value: assert property (index_load |-> index_value == $past(index_pair) + 16'h0001)
		else $error("post increment value wrong");
	chk_branch_add: assert property (run && branch_start && branch_taken |=>
		program_counter == $past(program_counter) + $past(disp_ext)) else $error("branch target wrong");
	chk_reset_force: assert property (disable iff (1'b0) !resetn |=> stack_pointer == 16'h00ff
		&& interrupt_mask && !mem_wr && !mem_rd) else $error("reset did not force state");
	chk_vector_fetch: assert property ($rose(resetn) |=> reset_fetch) else $error("reset fetch wrong");
	chk_entry_order: assert property (run && boundary && soft_trap_instr && !halt_to_debug_instr |=> ##1 entry_steps)
		else $error("entry sequence wrong");
	chk_wait_gate: assert property (run && boundary && wait_instr && !soft_trap_instr && !halt_to_debug_instr
		&& (interrupt_mask || !irq_pending) |=> !cpu_clk_en && !interrupt_mask) else $error("wait did not gate clocks");
	chk_halt_enter: assert property (run && boundary && halt_to_debug_instr |=> in_background)
		else $error("halt did not enter background");
	chk_bg_resume: assert property (in_background && debug_resume_cmd |=> !in_background)
		else $error("resume ignored");
	chk_mask_block: assert property (run && boundary && irq_pending && interrupt_mask && !soft_trap_instr
		|=> ##1 !mem_wr) else $error("masked request taken");
	function automatic logic ea_valid_gap();
		return !ea_mem_access;
	endfunction
endmodule
bind cams_core cams_chk u_chk (.clk, .resetn, .ea_start, .ea_mode, .op_lo, .index_pair, .branch_start, .branch_disp,
	.branch_taken, .boundary, .irq_pending, .soft_trap_instr, .wait_instr, .halt_to_debug_instr, .debug_resume_cmd,
	.ea_addr, .ea_mem_access, .index_load, .index_value, .program_counter, .stack_pointer, .interrupt_mask,
	.mem_addr, .mem_rd, .mem_wr, .cpu_clk_en, .in_background, .seq_busy);
`default_nettype wire

/* File: tb/cams_core_test.sv */
// Self-checking bench for the address-mode and sequence core.
`timescale 1ns/100ps
`default_nettype none
module cams_core_test;
	logic        clk, resetn, ea_start, ea_for_copy, ea_for_compare, branch_start, branch_taken, pc_step, boundary;
	logic        irq_pending, soft_trap_instr, wait_instr, stop_instr, halt_to_debug_instr, mask_clear_instr;
	logic        debug_enter_cmd, debug_resume_cmd, single_step_cmd, tagged_resume_cmd, debug_mode_enable_bit;
	logic        ea_valid, ea_mem_access, ea_illegal, index_load, interrupt_mask, mem_rd, mem_wr;
	logic        cpu_clk_en, osc_keep_on, in_background, seq_busy;
	logic [3:0]  ea_mode;
	logic [7:0]  op_hi, op_lo, branch_disp, index_low, accumulator, ccr_flags, mem_rdata, mem_wdata;
	logic [15:0] index_pair, irq_vector, ea_addr, index_value, program_counter, stack_pointer, mem_addr;
	int          errors, checked;
	cams_core DUT (.clk, .resetn, .ea_start, .ea_mode, .ea_for_copy, .ea_for_compare, .op_hi, .op_lo, .index_pair,
		.branch_start, .branch_disp, .branch_taken, .pc_step, .boundary, .irq_pending, .irq_vector, .soft_trap_instr,
		.wait_instr, .stop_instr, .halt_to_debug_instr, .mask_clear_instr, .index_low, .accumulator, .ccr_flags,
		.mem_rdata, .debug_enter_cmd, .debug_resume_cmd, .single_step_cmd, .tagged_resume_cmd, .debug_mode_enable_bit,
		.ea_addr, .ea_valid, .ea_mem_access, .ea_illegal, .index_load, .index_value, .program_counter, .stack_pointer,
		.interrupt_mask, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .cpu_clk_en, .osc_keep_on, .in_background, .seq_busy);
	cams_mem_model mm (.clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);
	// Free-running 50 MHz clock.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Waits for a sequence to finish; a hang counts as a mismatch and ends the run.
	task automatic settle;
		int i;
		tick(3);
		for (i = 0; i < 40 && seq_busy !== 1'b0; i++)
			tick(1);
		if (i == 40) begin
			errors++;
			tally_and_finish;
		end
	endtask
	// One boundary pulse; kind is {halt, trap, wait, stop, mask clear}.
	task automatic at_boundary(input logic [4:0] kind);
		{halt_to_debug_instr, soft_trap_instr, wait_instr, stop_instr, mask_clear_instr} = kind;
		boundary = 1'b1;
		tick(1);
		{halt_to_debug_instr, soft_trap_instr, wait_instr, stop_instr, mask_clear_instr} = 5'h00;
		boundary = 1'b0;
	endtask
	// A leading edge keeps two pulses in a row from touching one signal twice in a time step.
	task automatic command(input logic [3:0] which);
		tick(1);
		{debug_enter_cmd, debug_resume_cmd, single_step_cmd, tagged_resume_cmd} = which;
		tick(1);
		{debug_enter_cmd, debug_resume_cmd, single_step_cmd, tagged_resume_cmd} = 4'h0;
	endtask
	// Holds reset two cycles, then follows the vector fetch to run state.
	task automatic do_reset;
		resetn = 1'b0;
		tick(1);
		check({mem_rd, mem_wr}, 2'b00);
		tick(1);
		check({interrupt_mask, stack_pointer}, 17'h100ff);
		resetn = 1'b1;
		tick(1);
		check(mem_addr, 16'hfffe);
		settle;
		check(program_counter, 16'h1237);
	endtask
	// Requests stay back to back: ea_start is left high between calls.
	task automatic ea_req(input logic [3:0] mode, input logic [1:0] cls, input logic [15:0] op, input logic [15:0] ix,
		input logic [15:0] addr, input logic [2:0] flags);
		{ea_mode, ea_for_copy, ea_for_compare, op_hi, op_lo, index_pair} = {mode, cls, op, ix};
		ea_start = 1'b1;
		tick(1);
		check({ea_valid, ea_illegal, index_load}, {1'b1, flags[1:0]});
		check(ea_mem_access, flags[2]);
		if (flags[2])
			check(ea_addr, addr);
		if (flags[0])
			check(index_value, 16'(ix + 16'h0001));
	endtask
	task automatic stack_check(input logic [15:0] top, input logic [39:0] bytes);
		for (int i = 0; i < 5; i++)
			check(mm.mem[top - i], bytes[39 - 8 * i -: 8]);
	endtask
	task automatic trap_test;
		at_boundary(5'h08);
		settle;
		stack_check(16'h00ff, 40'h28125aa569);
		check(mm.mem[16'h00fa], 8'hee);
		check({interrupt_mask, program_counter, stack_pointer[7:0]}, 25'h14003fa);
	endtask
	task automatic wait_test;
		irq_pending = 1'b1;
		at_boundary(5'h00);
		tick(1);
		check(mem_wr, 1'b0);
		at_boundary(5'h04);
		check({cpu_clk_en, interrupt_mask}, 2'b00);
		settle;
		irq_pending = 1'b0;
		stack_check(16'h00fa, 40'h03405aa561);
		check(stack_pointer, 16'h00f5);
	endtask
	task automatic debug_test;
		at_boundary(5'h04);
		command(4'h8);
		check({cpu_clk_en, in_background}, 2'b11);
		command(4'h4);
		at_boundary(5'h02);
		command(4'h8);
		check(in_background, 1'b0);
		debug_mode_enable_bit = 1'b1;
		tick(1);
		check(osc_keep_on, 1'b1);
		command(4'h8);
		check({cpu_clk_en, in_background}, 2'b11);
		command(4'h4);
		for (int i = 0; i < 3; i++) begin
			// Let the run state settle so the halt is taken from a quiet core.
			tick(1);
			at_boundary(5'h10);
			tick(2);
			check(in_background, 1'b1);
			command(4'h4 >> i);
			check(in_background, 1'b0);
		end
	endtask
	initial begin
		{ea_start, ea_for_copy, ea_for_compare, branch_start, branch_taken, pc_step, boundary, irq_pending} = '0;
		{soft_trap_instr, wait_instr, stop_instr, halt_to_debug_instr, mask_clear_instr, debug_enter_cmd} = '0;
		{debug_resume_cmd, single_step_cmd, tagged_resume_cmd, debug_mode_enable_bit, resetn} = '0;
		{ea_mode, op_hi, op_lo, index_pair, branch_disp, errors, checked} = '0;
		{index_low, accumulator, ccr_flags, irq_vector} = 40'h5aa501ffe0;
		#1;
		{mm.mem[16'hfffe], mm.mem[16'hffff], mm.mem[16'hffe0], mm.mem[16'hffe1]} = 32'h12344000;
		do_reset;
		ea_req(4'h0, 2'b00, 16'h0000, 16'h0000, 16'h0000, 3'b000);
		ea_req(4'h1, 2'b00, 16'h1234, 16'h0000, 16'h1237, 3'b100);
		ea_req(4'h2, 2'b00, 16'hff80, 16'h0000, 16'h0080, 3'b100);
		ea_req(4'h3, 2'b00, 16'h1234, 16'h0000, 16'h1234, 3'b100);
		ea_req(4'h4, 2'b00, 16'h0000, 16'hfff0, 16'hfff0, 3'b100);
		ea_req(4'h5, 2'b10, 16'h0000, 16'hffff, 16'hffff, 3'b101);
		ea_req(4'h5, 2'b00, 16'h0000, 16'h0040, 16'h0000, 3'b010);
		ea_req(4'h6, 2'b00, 16'h00ff, 16'hfff0, 16'h00ef, 3'b100);
		ea_req(4'h7, 2'b01, 16'h0001, 16'h2000, 16'h2001, 3'b101);
		ea_req(4'h7, 2'b10, 16'h0001, 16'h2000, 16'h0000, 3'b010);
		ea_req(4'h8, 2'b00, 16'h8020, 16'h9000, 16'h1020, 3'b100);
		ea_req(4'h9, 2'b00, 16'h0010, 16'h0000, 16'h010f, 3'b100);
		ea_req(4'ha, 2'b00, 16'hff02, 16'h0000, 16'h0001, 3'b100);
		ea_start = 1'b0;
		{branch_start, branch_taken, branch_disp} = 10'h3f0;
		tick(1);
		check(program_counter, 16'h1227);
		{branch_taken, pc_step} = 2'b01;
		tick(1);
		check(program_counter, 16'h1228);
		{branch_start, pc_step} = 2'b00;
		trap_test;
		wait_test;
		debug_test;
		// Unmasked request on a mask-clear boundary must wait for the next one.
		tick(1);
		irq_pending = 1'b1;
		at_boundary(5'h01);
		check(seq_busy, 1'b0);
		irq_pending = 1'b0;
		tick(1);
		at_boundary(5'h08);
		tick(2);
		check(mem_wr, 1'b1);
		do_reset;
		tally_and_finish;
	end
endmodule
`default_nettype wire
